// *** design/ubf_pkg.sv ***
// constants, types and state layout for the uart baud/fifo block
package ubf_pkg;
  // --------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_LINE1  = 8'h00;
  localparam logic [7:0] ADDR_LINE2  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0c;
  localparam logic [7:0] ADDR_DIV_HI = 8'h10;
  localparam logic [7:0] ADDR_DIV_LO = 8'h14;
  localparam logic [7:0] ADDR_FMC    = 8'h18;
  localparam logic [7:0] ADDR_CNT    = 8'h1c;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int L1_EN    = 7;
  localparam int L1_LEN9  = 6;
  localparam int L1_PEN   = 5;
  localparam int L1_PTYPE = 3;
  localparam int L1_RX8   = 1;
  localparam int L1_TX8   = 0;
  localparam int L2_TXEN  = 7;
  localparam int L2_RXEN  = 6;
  localparam int L2_STOP2 = 5;
  localparam int L2_BRK   = 4;
  localparam int L2_RIE   = 2;
  localparam int FM_FRAC  = 3;
  localparam int FM_RSEL  = 2;
  localparam int FM_TRIG  = 0;
  // --------------------------------------------------------------
  // encodings and counts
  // --------------------------------------------------------------
  localparam logic [1:0]  PAR_EVEN   = 2'h0;
  localparam logic [1:0]  PAR_ODD    = 2'h1;
  localparam logic [1:0]  PAR_MARK   = 2'h2;
  localparam logic [1:0]  TRIG_FULL  = 2'h0;
  localparam int          FIFO_DEPTH = 4;
  localparam logic [2:0]  FIFO_FULL  = 3'h4;
  localparam logic [3:0]  LAST_BIT8  = 4'h7;
  localparam logic [3:0]  LAST_BIT9  = 4'h8;
  localparam logic [15:0] SMP_OFS1   = 16'h1;
  localparam logic [15:0] SMP_OFS2   = 16'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_PAR  = 3'b010, TX_STOP  = 3'b110
  } ubf_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR  = 3'b010, RX_STOP  = 3'b110
  } ubf_rx_e;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready, slverr, irq;
    logic        glb_en, len9, par_en, tx8;
    logic [1:0]  par_type;
    logic        tx_en, rx_en, stop2, brk, rie;
    logic [2:0]  frac;
    logic        rsel;
    logic [1:0]  trig;
    logic [7:0]  div_lo, div_hi;
    logic [15:0] div;
    logic        txif, tidle, rxif, oerr, ferr, perr, nf, ridle;
    ubf_tx_e     tx_st;
    logic [15:0] tx_cnt;
    logic        tx_ext;
    logic [2:0]  tx_acc;
    logic [3:0]  tx_bits;
    logic [8:0]  tx_sh, tx_hold;
    logic        tx_hold_full, tx_par, tx_out, tx_oe;
    ubf_rx_e     rx_st;
    logic        rx_q, rx_prev;
    logic [15:0] rx_cnt;
    logic        rx_ext;
    logic [2:0]  rx_acc;
    logic [3:0]  rx_bits;
    logic [8:0]  rx_sh;
    logic        smp_a, smp_b, rx_bit, rx_noisy, rx_perr, rx_own;
    logic [FIFO_DEPTH-1:0][8:0] fifo;
    logic [1:0]  rd_ptr;
    logic [2:0]  count;
    logic [8:0]  shreg;
    logic        shreg_full;
  } ubf_state_s;

  localparam ubf_state_s ST_RESET = '{txif: 1'b1, tidle: 1'b1, ridle: 1'b1,
    rx_q: 1'b1, rx_prev: 1'b1, tx_out: 1'b1, tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};
endpackage

// *** design/ubf_uart.sv ***
// uart baud generator, receive fifo and global enable with apb access
`timescale 1ns/1ps
module ubf_uart
  import ubf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             rx_own,
  output logic             irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ubf_state_s  s_ff, nxt_s;
  logic        acc_done, we, re, push, pop, tx_end, rx_end, vote;
  logic [3:0]  sum;
  logic [8:0]  rx_word;
  logic [15:0] smp0, smp1, smp2;
  logic [2:0]  thr;
  logic [31:0] rd_mux;

  function automatic logic par_bit(input logic [1:0] t, input logic [8:0] d,
                                   input logic l9);
    logic x;
    x = ^(l9 ? d : {1'b0, d[7:0]});
    case (t)
      PAR_EVEN: par_bit = x;
      PAR_ODD:  par_bit = ~x;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (paddr)
      ADDR_LINE1: begin
        rd_mux[L1_EN]              = s_ff.glb_en;
        rd_mux[L1_LEN9]            = s_ff.len9;
        rd_mux[L1_PEN]             = s_ff.par_en;
        rd_mux[L1_PTYPE +: 2]      = s_ff.par_type;
        rd_mux[L1_RX8]             = s_ff.fifo[s_ff.rd_ptr][8];
        rd_mux[L1_TX8]             = s_ff.tx8;
      end
      ADDR_LINE2: begin
        rd_mux[L2_TXEN]            = s_ff.tx_en;
        rd_mux[L2_RXEN]            = s_ff.rx_en;
        rd_mux[L2_STOP2]           = s_ff.stop2;
        rd_mux[L2_BRK]             = s_ff.brk;
        rd_mux[L2_RIE]             = s_ff.rie;
      end
      ADDR_STATUS: rd_mux[7:0] = {s_ff.perr, s_ff.nf, s_ff.ferr, s_ff.oerr,
                                  s_ff.ridle, s_ff.rxif, s_ff.tidle, s_ff.txif};
      ADDR_DATA:   rd_mux[7:0] = s_ff.fifo[s_ff.rd_ptr][7:0];
      ADDR_DIV_HI: rd_mux[7:0] = s_ff.div_hi;
      ADDR_DIV_LO: rd_mux[7:0] = s_ff.div_lo;
      ADDR_FMC: begin
        rd_mux[FM_FRAC +: 3]       = s_ff.frac;
        rd_mux[FM_RSEL]            = s_ff.rsel;
        rd_mux[FM_TRIG +: 2]       = s_ff.trig;
      end
      ADDR_CNT:    rd_mux[2:0] = s_ff.count;
      default:     rd_mux = '0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    acc_done = psel & penable & s_ff.ready;
    we       = acc_done & pwrite;
    re       = acc_done & ~pwrite;
    push     = 1'b0;
    pop      = 1'b0;
    rx_word  = '0;
    vote     = 1'b0;
    // zero-wait slave is impossible with registered outputs: one wait state
    nxt_s.ready  = psel & penable & ~s_ff.ready;
    nxt_s.slverr = 1'b0;
    if (psel & penable & ~s_ff.ready) begin
      nxt_s.rdata  = rd_mux;
      nxt_s.slverr = (paddr[1:0] != 2'h0) || (paddr > ADDR_CNT);
    end
    if (we) begin
      case (paddr)
        ADDR_LINE1: begin
          nxt_s.glb_en   = pwdata[L1_EN];
          nxt_s.len9     = pwdata[L1_LEN9];
          nxt_s.par_en   = pwdata[L1_PEN];
          nxt_s.par_type = pwdata[L1_PTYPE +: 2];
          nxt_s.tx8      = pwdata[L1_TX8];
        end
        ADDR_LINE2: begin
          nxt_s.tx_en = pwdata[L2_TXEN];
          nxt_s.rx_en = pwdata[L2_RXEN];
          nxt_s.stop2 = pwdata[L2_STOP2];
          nxt_s.brk   = pwdata[L2_BRK];
          nxt_s.rie   = pwdata[L2_RIE];
        end
        // full 16-bit divisor on high byte
        ADDR_DIV_HI: begin
          nxt_s.div_hi = pwdata[7:0];
          nxt_s.div    = {pwdata[7:0], s_ff.div_lo};
        end
        ADDR_DIV_LO: nxt_s.div_lo = pwdata[7:0];
        ADDR_FMC: begin
          nxt_s.frac = pwdata[FM_FRAC +: 3];
          nxt_s.rsel = pwdata[FM_RSEL];
          nxt_s.trig = pwdata[FM_TRIG +: 2];
        end
        // write ignored while the holding register is full
        ADDR_DATA: if (s_ff.txif && s_ff.tx_en) begin
          nxt_s.tx_hold      = {s_ff.tx8, pwdata[7:0]};
          nxt_s.tx_hold_full = 1'b1;
          nxt_s.txif         = 1'b0;
          nxt_s.tidle        = 1'b0;
        end
        default: ;
      endcase
    end
    // read pops fifo, clears error flags
    if (re && paddr == ADDR_DATA) begin
      nxt_s.ferr = 1'b0;
      nxt_s.perr = 1'b0;
      nxt_s.nf   = 1'b0;
      nxt_s.oerr = 1'b0;
      if (s_ff.count != 3'h0) begin
        pop          = 1'b1;
        nxt_s.rd_ptr = s_ff.rd_ptr + 2'h1;
        nxt_s.count  = s_ff.count - 3'h1;
        // held byte moves into freed slot
        if (s_ff.shreg_full) begin
          nxt_s.fifo[s_ff.rd_ptr] = s_ff.shreg;
          nxt_s.count             = s_ff.count;
          nxt_s.shreg_full        = 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    // carry into bit 3 adds a clock
    sum    = {1'b0, s_ff.tx_acc} + {1'b0, s_ff.frac};
    tx_end = ({1'b0, s_ff.tx_cnt} + 17'h1) == ({1'b0, s_ff.div} + {16'h0, s_ff.tx_ext});
    if (s_ff.tx_st != TX_IDLE) begin
      nxt_s.tx_cnt = tx_end ? 16'h0 : s_ff.tx_cnt + 16'h1;
      if (tx_end) begin
        nxt_s.tx_ext = sum[3];
        nxt_s.tx_acc = sum[2:0];
      end
    end
    case (s_ff.tx_st)
      TX_IDLE: begin
        nxt_s.tx_out = 1'b1;
        if (s_ff.tx_hold_full) begin
          nxt_s.tx_acc       = s_ff.frac;
          nxt_s.tx_ext       = 1'b0;
          nxt_s.tx_cnt       = 16'h0;
          nxt_s.tx_sh        = s_ff.tx_hold;
          nxt_s.tx_par       = par_bit(s_ff.par_type, s_ff.tx_hold, s_ff.len9);
          nxt_s.tx_hold_full = 1'b0;
          nxt_s.txif         = 1'b1;
          nxt_s.tx_bits      = 4'h0;
          nxt_s.tx_out       = 1'b0;
          nxt_s.tx_st        = TX_START;
        end
      end
      TX_START: if (tx_end) begin
        nxt_s.tx_out = s_ff.tx_sh[0];
        nxt_s.tx_st  = TX_DATA;
      end
      TX_DATA: if (tx_end) begin
        nxt_s.tx_sh   = {1'b0, s_ff.tx_sh[8:1]};
        nxt_s.tx_bits = s_ff.tx_bits + 4'h1;
        nxt_s.tx_out  = s_ff.tx_sh[1];
        if (s_ff.tx_bits == (s_ff.len9 ? LAST_BIT9 : LAST_BIT8)) begin
          nxt_s.tx_bits = 4'h0;
          nxt_s.tx_out  = s_ff.par_en ? s_ff.tx_par : 1'b1;
          nxt_s.tx_st   = s_ff.par_en ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR: if (tx_end) begin
        nxt_s.tx_out = 1'b1;
        nxt_s.tx_st  = TX_STOP;
      end
      TX_STOP: if (tx_end) begin
        // second stop bit on transmit only
        if (s_ff.stop2 && s_ff.tx_bits == 4'h0) begin
          nxt_s.tx_bits = 4'h1;
        end else begin
          nxt_s.tx_st = TX_IDLE;
          if (!nxt_s.tx_hold_full) nxt_s.tidle = 1'b1;
        end
      end
      default: nxt_s.tx_st = TX_IDLE;
    endcase

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    nxt_s.rx_q    = rx_in;
    nxt_s.rx_prev = s_ff.rx_q;
    smp0   = {1'b0, s_ff.div[15:1]} - {15'h0, s_ff.rsel};
    smp1   = {1'b0, s_ff.div[15:1]} + SMP_OFS1 - {15'h0, s_ff.rsel};
    smp2   = {1'b0, s_ff.div[15:1]} + SMP_OFS2;
    rx_end = ({1'b0, s_ff.rx_cnt} + 17'h1) == ({1'b0, s_ff.div} + {16'h0, s_ff.rx_ext});
    if (s_ff.rx_st != RX_IDLE) begin
      nxt_s.rx_cnt = rx_end ? 16'h0 : s_ff.rx_cnt + 16'h1;
      if (s_ff.rx_cnt == smp0) nxt_s.smp_a = s_ff.rx_q;
      if (s_ff.rx_cnt == smp1) nxt_s.smp_b = s_ff.rx_q;
      if (s_ff.rx_cnt == smp2) begin
        vote         = (s_ff.smp_a & s_ff.smp_b) | (s_ff.rx_q & (s_ff.smp_a | s_ff.smp_b));
        nxt_s.rx_bit = vote;
        if (!(s_ff.smp_a == s_ff.smp_b && s_ff.smp_b == s_ff.rx_q))
          nxt_s.rx_noisy = 1'b1;
      end
      if (rx_end) begin
        nxt_s.rx_ext = ({1'b0, s_ff.rx_acc} + {1'b0, s_ff.frac}) >= 4'h8;
        nxt_s.rx_acc = s_ff.rx_acc + s_ff.frac;
      end
    end
    rx_word = s_ff.len9 ? s_ff.rx_sh : {1'b0, s_ff.rx_sh[8:1]};
    case (s_ff.rx_st)
      RX_IDLE: if (s_ff.rx_own && s_ff.rx_prev && !s_ff.rx_q) begin
        nxt_s.rx_acc   = s_ff.frac;
        nxt_s.rx_ext   = 1'b0;
        nxt_s.rx_cnt   = 16'h0;
        nxt_s.rx_bits  = 4'h0;
        nxt_s.rx_noisy = 1'b0;
        nxt_s.ridle    = 1'b0;
        nxt_s.rx_st    = RX_START;
      end
      RX_START: if (rx_end) begin
        // false start returns to idle
        nxt_s.rx_st = s_ff.rx_bit ? RX_IDLE : RX_DATA;
        nxt_s.ridle = s_ff.rx_bit;
      end
      RX_DATA: if (rx_end) begin
        nxt_s.rx_sh   = {s_ff.rx_bit, s_ff.rx_sh[8:1]};
        nxt_s.rx_bits = s_ff.rx_bits + 4'h1;
        if (s_ff.rx_bits == (s_ff.len9 ? LAST_BIT9 : LAST_BIT8))
          nxt_s.rx_st = s_ff.par_en ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (rx_end) begin
        nxt_s.rx_perr = s_ff.rx_bit != par_bit(s_ff.par_type, rx_word, s_ff.len9);
        nxt_s.rx_st   = RX_STOP;
      end
      // receiver checks one stop bit
      // ends just after the stop vote so a back-to-back start is not missed
      RX_STOP: if (s_ff.rx_cnt == smp2 + SMP_OFS1) begin
        push        = 1'b1;
        nxt_s.rx_st = RX_IDLE;
        nxt_s.ridle = 1'b1;
        if (!s_ff.rx_bit) nxt_s.ferr = 1'b1;
        if (s_ff.par_en && s_ff.rx_perr) nxt_s.perr = 1'b1;
        if (s_ff.rx_noisy) nxt_s.nf = 1'b1;
      end
      default: nxt_s.rx_st = RX_IDLE;
    endcase
    // push after pop so a same-cycle read frees room
    if (push) begin
      if (nxt_s.count != FIFO_FULL) begin
        nxt_s.fifo[2'(nxt_s.rd_ptr + nxt_s.count[1:0])] = rx_word;
        nxt_s.count = nxt_s.count + 3'h1;
      end else begin
        if (nxt_s.shreg_full) nxt_s.oerr = 1'b1;
        nxt_s.shreg      = rx_word;
        nxt_s.shreg_full = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // enables and disable
    // ------------------------------------------------------------
    // disable clears state, tx/rx enables and break, keeps other configuration
    if (!nxt_s.glb_en) begin
      nxt_s.tx_en        = 1'b0;
      nxt_s.rx_en        = 1'b0;
      nxt_s.brk          = 1'b0;
      nxt_s.oerr         = 1'b0;
      nxt_s.ferr         = 1'b0;
      nxt_s.perr         = 1'b0;
      nxt_s.nf           = 1'b0;
      nxt_s.count        = 3'h0;
      nxt_s.rd_ptr       = 2'h0;
      nxt_s.shreg_full   = 1'b0;
      nxt_s.tx_hold_full = 1'b0;
      nxt_s.txif         = 1'b1;
      nxt_s.tidle        = 1'b1;
    end
    if (!nxt_s.tx_en) nxt_s.tx_st = TX_IDLE;
    if (!nxt_s.rx_en) begin
      nxt_s.rx_st = RX_IDLE;
      nxt_s.ridle = 1'b1;
    end
    thr        = (nxt_s.trig == TRIG_FULL) ? FIFO_FULL : {1'b0, nxt_s.trig};
    nxt_s.rxif = nxt_s.glb_en && (nxt_s.count >= thr);
    // interrupt from overrun or rx available
    nxt_s.irq  = nxt_s.rie && (nxt_s.rxif || nxt_s.oerr);
    // idle high, pins released when not enabled
    nxt_s.tx_oe  = nxt_s.glb_en && nxt_s.tx_en;
    nxt_s.rx_own = nxt_s.glb_en && nxt_s.rx_en;
    if (nxt_s.tx_st == TX_IDLE) nxt_s.tx_out = 1'b1;
    if (nxt_s.brk) nxt_s.tx_out = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= ST_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata  = s_ff.rdata;
  assign pready  = s_ff.ready;
  assign pslverr = s_ff.slverr;
  assign tx_out  = s_ff.tx_out;
  assign tx_oe   = s_ff.tx_oe;
  assign rx_own  = s_ff.rx_own;
  assign irq     = s_ff.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bit_len;
    s_ff.tx_st != TX_IDLE |-> ({1'b0, s_ff.tx_cnt} < ({1'b0, s_ff.div} + {16'h0, s_ff.tx_ext}));
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit timer overran");
  property p_frame_acc;
    (s_ff.tx_st == TX_IDLE && nxt_s.tx_st == TX_START) |=> (s_ff.tx_acc == $past(s_ff.frac) && !s_ff.tx_ext);
  endproperty
  a_frame_acc: assert property (p_frame_acc) else $error("accumulator not reset");
  property p_trig;
    s_ff.glb_en |-> s_ff.rxif == (s_ff.count >= ((s_ff.trig == TRIG_FULL) ? FIFO_FULL : {1'b0, s_ff.trig}));
  endproperty
  a_trig: assert property (p_trig) else $error("rx available flag wrong");
  property p_cnt_max;
    s_ff.count <= FIFO_FULL;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("fill count above four");
  property p_pop;
    (pop && !push && !s_ff.shreg_full && s_ff.glb_en) |=> s_ff.count == $past(s_ff.count) - 3'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not decrement");
  property p_disable;
    !s_ff.glb_en |-> (s_ff.count == 3'h0 && s_ff.txif && s_ff.tidle && s_ff.ridle && !s_ff.oerr && !s_ff.tx_en);
  endproperty
  a_disable: assert property (p_disable) else $error("disable state wrong");
  property p_keep_div;
    $fell(s_ff.glb_en) |-> s_ff.div == $past(s_ff.div);
  endproperty
  a_keep_div: assert property (p_keep_div) else $error("divisor lost on disable");
  property p_idle_high;
    (s_ff.tx_st == TX_IDLE && !s_ff.brk) |-> s_ff.tx_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_irq;
    (s_ff.rie && (s_ff.rxif || s_ff.oerr)) |-> s_ff.irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_push:    cover property (push);
  c_overrun: cover property ($rose(s_ff.oerr));
  c_txframe: cover property (s_ff.tx_st == TX_STOP ##1 s_ff.tx_st == TX_IDLE);
  c_disable: cover property ($fell(s_ff.glb_en));
endmodule

// *** tb/ubf_remote.sv ***
// remote serial transceiver model on the far side of the line
`timescale 1ns/1ps
module ubf_remote (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  // --------------------------------------------------------------
  // idle line
  // --------------------------------------------------------------
  initial line_out = 1'b1;

  // --------------------------------------------------------------
  // frame sender
  // --------------------------------------------------------------
  // start, lsb first, stop
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (bt - 1) @(posedge clk);
    end
  endtask

  // --------------------------------------------------------------
  // frame receiver
  // --------------------------------------------------------------
  // mid-bit sampling, one stop
  task automatic recv(output logic [7:0] b, output logic ok, input int bt);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line_in !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n < 5000) begin
      ok = 1'b1;
      // skip start bit, land mid data bit
      repeat (bt + bt / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        b[i] = line_in;
        repeat (bt) @(posedge clk);
      end
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking apb testbench for the uart baud/fifo block
`timescale 1ns/1ps
module tb_top
  import ubf_pkg::*;
();
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam int BT = 16;
  logic        pclk, presetn, psel, penable, pwrite, rx_in;
  logic        tx_out, tx_oe, rx_own, irq, pready, pslverr, ok;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, cmp_count, n;
  // released pin pulled up
  wire         ser_line = tx_oe ? tx_out : 1'b1;

  ubf_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_own(rx_own), .irq(irq));
  ubf_remote peer (.clk(pclk), .line_in(ser_line), .line_out(rx_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  function automatic logic [7:0] val(input int i);
    return 8'h5a + 8'(i) * 8'h21;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one idle cycle first, so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    ok = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    fail_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", ADDR_STATUS, 32'h0b);
    rdc("count", ADDR_CNT, 32'h0);
    rdc("line1", ADDR_LINE1, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(ok));
    wr(ADDR_LINE1, 32'h80);
    wr(ADDR_LINE2, 32'hc4);
    wr(ADDR_DIV_LO, 32'h10);
    wr(ADDR_DIV_HI, 32'h0);
    chk("tx_oe", 32'h1, 32'(tx_oe));
    chk("rx_own", 32'h1, 32'(rx_own));
    chk("tx_idle", 32'h1, 32'(tx_out));
    // four bytes in, then drained under every trigger level
    for (int i = 0; i < 4; i++) peer.send(val(i), BT);
    repeat (4) @(posedge pclk);
    for (int c = 4; c > 0; c--) begin
      for (int t = 0; t < 4; t++) begin
        wr(ADDR_FMC, 32'(t));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("rxif", {31'h0, c >= ((t == 0) ? 4 : t)}, {31'h0, rd[2]});
      end
      rdc("data", ADDR_DATA, 32'(val(4 - c)));
      rdc("count", ADDR_CNT, 32'(c - 1));
    end
    // six bytes: fifo holds four, sixth overruns
    wr(ADDR_FMC, 32'h01);
    for (int i = 0; i < 6; i++) peer.send(val(i), BT);
    repeat (4) @(posedge pclk);
    rdc("count", ADDR_CNT, 32'h4);
    rdc("status", ADDR_STATUS, 32'h1f);
    chk("irq", 32'h1, 32'(irq));
    // disable drops flags, tx/rx enables and break, keeps other configuration
    wr(ADDR_LINE1, 32'h0);
    rdc("line2", ADDR_LINE2, 32'h04);
    rdc("status", ADDR_STATUS, 32'h0b);
    rdc("count", ADDR_CNT, 32'h0);
    rdc("fmc", ADDR_FMC, 32'h01);
    rdc("div_lo", ADDR_DIV_LO, 32'h10);
    chk("tx_oe", 32'h0, 32'(tx_oe));
    chk("rx_own", 32'h0, 32'(rx_own));
    chk("irq", 32'h0, 32'(irq));
    wr(ADDR_LINE1, 32'h80);
    wr(ADDR_LINE2, 32'hc4);
    wr(ADDR_DATA, 32'ha5);
    peer.recv(b, ok, BT);
    chk("tx_ok", 32'h1, 32'(ok));
    chk("tx_byte", 32'ha5, 32'(b));
    // even parity: 0xa4 has three ones, so the parity bit is high
    wr(ADDR_LINE1, 32'ha0);
    wr(ADDR_DATA, 32'ha4);
    peer.recv(b, ok, BT);
    chk("par_byte", 32'ha4, 32'(b));
    chk("par_bit", 32'h1, 32'(ser_line));
    wr(ADDR_LINE1, 32'h80);
    // fraction three: start plus zero byte lengthened three times
    wr(ADDR_FMC, 32'h19);
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_DATA, 32'h0);
      n = 0;
      while (ser_line !== 1'b0 && n < 400) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      while (ser_line === 1'b0 && n < 400) begin
        @(posedge pclk);
        n++;
      end
      chk("low_run", 32'h93, 32'(n));
    end
    // let the last frame finish before the divisor shrinks under it
    repeat (20) @(posedge pclk);
    // range select set with the smallest divisor
    wr(ADDR_FMC, 32'h05);
    wr(ADDR_DIV_LO, 32'h08);
    wr(ADDR_DIV_HI, 32'h0);
    peer.send(8'hc3, 8);
    repeat (4) @(posedge pclk);
    rdc("data8", ADDR_DATA, 32'hc3);
    // break holds the line low; disable must clear it
    wr(ADDR_LINE2, 32'hd4);
    @(posedge pclk);
    chk("brk_low", 32'h0, 32'(tx_out));
    wr(ADDR_LINE1, 32'h0);
    rdc("line2_brk", ADDR_LINE2, 32'h04);
    chk("brk_idle", 32'h1, 32'(tx_out));
    tally_and_finish();
  end
endmodule
